// ---- rtl/rxeq_adapt_status.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE_01: restart bit restarts search from any state
// RULE_02: search keeps stepping gains while unlocked
// RULE_03: compatible partner: restart once after first lock
// RULE_04: restart or port reset start from minimum
// RULE_05: ceiling field caps highest gain
// RULE_06: floor value is start and lowest gain
// RULE_07: floor only applies when floor enable set
// RULE_08: host programs narrow range around nominal gain
// RULE_09: chosen gain readable in result register
// RULE_10: wait dwell interval at each gain
// RULE_11: default dwell 2.62 ms of reference clock
// RULE_12: past ceiling wrap to minimum or floor
// RULE_13: three error sources individually selectable
// RULE_14: errors accumulated over half the dwell
// RULE_15: errors above threshold step gain up
// RULE_16: port conditions latched in two status registers
// RULE_17: lock change, crc, sequence flags clear on read
// RULE_18: 16-bit parity counter, high and low bytes
// RULE_19: parity flag set when count reaches threshold
// RULE_20: counter read clears counter and flag
// RULE_21: parity flag can raise an interrupt
// RULE_22: unlock clears parity counter and flag
// RULE_23: host disables parity check before exact read
// RULE_24: hold gain while lock persists
// RULE_25: lock loss resumes search at next gain
// RULE_26: restart request is one cycle, self-clearing
module rxeq_adapt_status (
  input wire logic sys_clk,
  input wire logic reset,
  input wire rxeq_pkg::rxeq_req_type reg_req,
  output logic [7:0] reg_rdata_q,
  input wire rxeq_pkg::rxeq_err_type link_errors,
  input wire logic cdr_lock_pin,
  input wire logic reference_clock,
  input wire logic partner_compatible,
  input wire logic port_logic_reset,
  output logic [3:0] eq_gain_q,
  output logic parity_irq_q
);
  import rxeq_pkg::*;

  logic [2:0] lock_s_q;
  logic lock_q;
  logic lock_d1_q;
  logic [2:0] ref_s_q;
  logic ref_q;
  logic ref_d1_q;
  logic [7:0] gen_cfg_q;
  logic [7:0] err_src_q;
  logic [7:0] par_thr_q;
  logic [7:0] eq_ctl_q;
  logic [7:0] eq_rng_q;
  logic restart_q;
  logic first_done_q;
  rxeq_state_type state_q;
  rxeq_state_type state_d;
  logic [3:0] gain_d;
  logic [19:0] dwell_q;
  logic [19:0] dwell_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [15:0] par_cnt_q;
  logic [15:0] par_cnt_d;
  logic [7:0] par_lo_shadow_q;
  logic par_flag_q;
  logic par_flag_d;
  logic lock_chg_q;
  logic crc_q;
  logic seq_q;

  // three-stage synchronisers; change accepted once stages 2 and 3 agree
  // stage 1 may go metastable, so only stage 2 ever reads it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_s_q <= 3'h0;
    end else begin
      lock_s_q <= {lock_s_q[1:0], cdr_lock_pin};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_s_q <= 3'h0;
    end else begin
      ref_s_q <= {ref_s_q[1:0], reference_clock};
    end
  end

  wire lock_agree = lock_s_q[1] == lock_s_q[2];
  wire ref_agree = ref_s_q[1] == ref_s_q[2];

  // filtered lock holds until stages 2 and 3 agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_q <= 1'b0;
      lock_d1_q <= 1'b0;
    end else begin
      lock_q <= lock_agree ? lock_s_q[2] : lock_q;
      lock_d1_q <= lock_q;
    end
  end

  // resets low like the idle pin, so no false tick after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_q <= 1'b0;
      ref_d1_q <= 1'b0;
    end else begin
      ref_q <= ref_agree ? ref_s_q[2] : ref_q;
      ref_d1_q <= ref_q;
    end
  end

  wire ref_tick = ref_q & ~ref_d1_q;
  wire lock_rise = lock_q & ~lock_d1_q;
  wire lock_fall = ~lock_q & lock_d1_q;

  // register access decode
  wire hit_gen = reg_req.addr == ADDR_GEN_CFG;
  wire hit_src = reg_req.addr == ADDR_ERR_SRC;
  wire hit_sts1 = reg_req.addr == ADDR_STS_ONE;
  wire hit_sts2 = reg_req.addr == ADDR_STS_TWO;
  wire hit_phi = reg_req.addr == ADDR_PAR_HI;
  wire hit_plo = reg_req.addr == ADDR_PAR_LO;
  wire hit_thr = reg_req.addr == ADDR_PAR_THR;
  wire hit_ctl = reg_req.addr == ADDR_EQ_CTL;
  wire hit_res = reg_req.addr == ADDR_EQ_RES;
  wire hit_rng = reg_req.addr == ADDR_EQ_RNG;
  wire rd_sts1 = reg_req.rd & hit_sts1;
  wire rd_sts2 = reg_req.rd & hit_sts2;
  wire rd_phi = reg_req.rd & hit_phi;
  wire rd_plo = reg_req.rd & hit_plo;
  wire wr_ctl = reg_req.wr & hit_ctl;
  wire wr_gen = reg_req.wr & hit_gen;
  wire wr_src = reg_req.wr & hit_src;
  wire wr_thr = reg_req.wr & hit_thr;
  wire wr_rng = reg_req.wr & hit_rng;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) gen_cfg_q <= RST_GEN_CFG;
    else if (wr_gen) gen_cfg_q <= reg_req.wdata;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) err_src_q <= RST_ERR_SRC;
    else if (wr_src) err_src_q <= reg_req.wdata;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) par_thr_q <= RST_PAR_THR;
    else if (wr_thr) par_thr_q <= reg_req.wdata;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) eq_rng_q <= RST_EQ_RNG;
    else if (wr_rng) eq_rng_q <= reg_req.wdata;
  end

  // restart bit is not stored in the control register itself
  wire [7:0] ctl_wdata = reg_req.wdata & ~(8'h01 << CTL_RESTART);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      eq_ctl_q <= RST_EQ_CTL;
      restart_q <= 1'b0;
    end else begin
      if (wr_ctl) eq_ctl_q <= ctl_wdata;
      // RULE_26: one-cycle request
      restart_q <= wr_ctl & reg_req.wdata[CTL_RESTART];
    end
  end

  // RULE_03: single restart after first lock
  wire first_lock_restart = lock_rise & partner_compatible
    & err_src_q[SRC_FIRST_LOCK_RESTART] & ~first_done_q;

  // once per reset; later lock edges do not restart
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) first_done_q <= 1'b0;
    else if (first_lock_restart) first_done_q <= 1'b1;
  end

  // RULE_01: restart from any state
  wire restart_req = restart_q | port_logic_reset | first_lock_restart;

  // search limits
  // RULE_06: floor is start gain
  wire [3:0] floor_val = eq_rng_q[RNG_FLOOR_LSB +: 4];
  wire [3:0] ceiling = eq_rng_q[RNG_CEIL_LSB +: 4];
  // RULE_07: floor active only when enabled
  wire [3:0] gain_min = eq_ctl_q[CTL_FLOOR_EN] ? floor_val : 4'h0;
  // RULE_05: ceiling caps the step
  wire at_top = eq_gain_q >= ceiling;
  // RULE_12: wrap to minimum or floor
  wire [3:0] gain_next = at_top ? gain_min : eq_gain_q + 4'h1;

  // RULE_11: dwell counted in reference clock edges
  wire [2:0] dwell_sel = eq_ctl_q[CTL_DWELL_LSB +: 3];
  wire [19:0] dwell_len = DWELL_UNIT << dwell_sel;
  wire [19:0] half_len = dwell_len >> 1;
  // a shorter dwell written mid-interval must not strand the counter
  wire dwell_end = ref_tick & (dwell_q >= dwell_len - 20'h1);
  wire half_end = ref_tick & (dwell_q == half_len - 20'h1);
  // errors in the second half are not tallied
  wire in_first_half = dwell_q < half_len;

  // RULE_13: selectable error sources
  wire sel_clk = link_errors.clk_recovery & err_src_q[SRC_CLK_RECOVERY];
  wire sel_enc = link_errors.encoding & err_src_q[SRC_ENCODING];
  wire sel_par = link_errors.parity & err_src_q[SRC_PARITY];
  wire [1:0] err_sum = {1'b0, sel_clk} + {1'b0, sel_enc} + {1'b0, sel_par};
  wire [8:0] acc_sum = {1'b0, acc_q} + {7'h00, err_sum};
  wire [7:0] acc_sat = acc_sum[8] ? ACC_MAX : acc_sum[7:0];
  wire [7:0] err_thold = {4'h0, err_src_q[SRC_THOLD_LSB +: 4]};
  wire err_over = acc_q > err_thold;

  always_comb begin
    state_d = state_q;
    gain_d = eq_gain_q;
    dwell_d = dwell_q + {19'h0, ref_tick};
    // RULE_14: accumulate during first half only
    acc_d = in_first_half ? acc_sat : acc_q;
    if (restart_req) begin
      // RULE_04: start over from minimum gain
      state_d = ST_SEARCH;
      gain_d = gain_min;
      dwell_d = 20'h0;
      acc_d = 8'h00;
    end else begin
      unique case (state_q)
        ST_SEARCH: begin
          if (half_end && err_over) begin
            // RULE_15: too many errors, step to gain_next (wraps to minimum at ceiling)
            gain_d = gain_next;
            dwell_d = 20'h0;
            acc_d = 8'h00;
          end else if (dwell_end) begin
            // RULE_10: full dwell ended with no error step at half dwell; hold if locked, else step
            dwell_d = 20'h0;
            acc_d = 8'h00;
            if (lock_q) begin
              // RULE_24: lock found, hold setting
              state_d = ST_HOLD;
            end else begin
              // RULE_02: keep stepping while unlocked
              gain_d = gain_next;
            end
          end
        end
        ST_HOLD: begin
          dwell_d = 20'h0;
          acc_d = 8'h00;
          if (!lock_q) begin
            // RULE_25: resume at next gain
            state_d = ST_SEARCH;
            gain_d = gain_next;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_SEARCH;
      eq_gain_q <= 4'h0;
    end else begin
      state_q <= state_d;
      eq_gain_q <= gain_d;
    end
  end

  // dwell and error tally always restart together
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dwell_q <= 20'h0;
      acc_q <= 8'h00;
    end else begin
      dwell_q <= dwell_d;
      acc_q <= acc_d;
    end
  end

  // parity counting
  wire par_evt = link_errors.parity & gen_cfg_q[GEN_PAR_CHECK];
  // RULE_22: unlock clears counter and flag
  wire unlock_clr = lock_fall & gen_cfg_q[GEN_CLR_ON_UNLOCK];
  // RULE_20: reading either byte clears
  wire par_clr = rd_phi | rd_plo | unlock_clr;
  wire par_full = par_cnt_q == PAR_MAX;
  // threshold zero keeps the flag quiet
  wire par_thr_on = par_thr_q != 8'h00;

  always_comb begin
    // RULE_18: saturating 16-bit count, new error survives clear
    if (par_clr) par_cnt_d = {15'h0000, par_evt};
    else if (par_full) par_cnt_d = par_cnt_q;
    else par_cnt_d = par_cnt_q + {15'h0000, par_evt};
    // RULE_19: flag once count reaches threshold
    par_flag_d = (par_flag_q & ~par_clr)
      | (par_evt & par_thr_on & (par_cnt_d >= {8'h00, par_thr_q}));
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      par_cnt_q <= 16'h0000;
      par_flag_q <= 1'b0;
    end else begin
      par_cnt_q <= par_cnt_d;
      par_flag_q <= par_flag_d;
    end
  end

  // high read snapshots low byte so the pair stays coherent
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) par_lo_shadow_q <= 8'h00;
    else if (rd_phi) par_lo_shadow_q <= par_cnt_q[7:0];
  end

  // RULE_21: interrupt follows flag
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) parity_irq_q <= 1'b0;
    else parity_irq_q <= par_flag_d;
  end

  // RULE_17: sticky until read, set wins over clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) lock_chg_q <= 1'b0;
    else lock_chg_q <= (lock_chg_q & ~rd_sts1) | (lock_q ^ lock_d1_q);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) crc_q <= 1'b0;
    else crc_q <= (crc_q & ~rd_sts2) | link_errors.crc;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) seq_q <= 1'b0;
    else seq_q <= (seq_q & ~rd_sts2) | link_errors.seq;
  end

  // RULE_16: latched port conditions
  wire [7:0] sts1_val = (8'(lock_q) << STS1_LOCK)
    | (8'(par_flag_q) << STS1_PAR_FLAG)
    | (8'(lock_chg_q) << STS1_LOCK_CHG);
  wire [7:0] sts2_val = (8'(crc_q) << STS2_CRC) | (8'(seq_q) << STS2_SEQ);
  // low byte always returns the snapshot taken at the last high read
  wire [7:0] plo_val = par_lo_shadow_q;
  // RULE_09: chosen gain readable
  wire [7:0] res_val = {4'h0, eq_gain_q};

  // unmapped offsets read back as zero
  wire [7:0] rd_mux =
    hit_gen ? gen_cfg_q :
    hit_src ? err_src_q :
    hit_sts1 ? sts1_val :
    hit_sts2 ? sts2_val :
    hit_phi ? par_cnt_q[15:8] :
    hit_plo ? plo_val :
    hit_thr ? par_thr_q :
    hit_ctl ? eq_ctl_q :
    hit_res ? res_val :
    hit_rng ? eq_rng_q : 8'h00;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) reg_rdata_q <= 8'h00;
    else if (reg_req.rd) reg_rdata_q <= rd_mux;
  end
endmodule

// ---- rtl/rxeq_pkg.sv ----
package rxeq_pkg;
  // register offsets
  localparam logic [7:0] ADDR_GEN_CFG = 8'h02;
  localparam logic [7:0] ADDR_ERR_SRC = 8'h42;
  localparam logic [7:0] ADDR_STS_ONE = 8'h4d;
  localparam logic [7:0] ADDR_STS_TWO = 8'h4e;
  localparam logic [7:0] ADDR_PAR_HI = 8'h55;
  localparam logic [7:0] ADDR_PAR_LO = 8'h56;
  localparam logic [7:0] ADDR_PAR_THR = 8'h57;
  localparam logic [7:0] ADDR_EQ_CTL = 8'hd2;
  localparam logic [7:0] ADDR_EQ_RES = 8'hd3;
  localparam logic [7:0] ADDR_EQ_RNG = 8'hd5;
  // reset values
  localparam logic [7:0] RST_GEN_CFG = 8'h03;
  localparam logic [7:0] RST_ERR_SRC = 8'h1f;
  localparam logic [7:0] RST_PAR_THR = 8'h01;
  localparam logic [7:0] RST_EQ_CTL = 8'h40;
  localparam logic [7:0] RST_EQ_RNG = 8'hf0;
  // general_config fields
  localparam int GEN_PAR_CHECK = 0;
  localparam int GEN_CLR_ON_UNLOCK = 1;
  // eq_error_source_ctl fields
  localparam int SRC_CLK_RECOVERY = 0;
  localparam int SRC_ENCODING = 1;
  localparam int SRC_PARITY = 2;
  localparam int SRC_FIRST_LOCK_RESTART = 3;
  localparam int SRC_THOLD_LSB = 4;
  // eq_adapt_control fields
  localparam int CTL_RESTART = 0;
  localparam int CTL_FLOOR_EN = 2;
  localparam int CTL_DWELL_LSB = 4;
  // eq_gain_range fields
  localparam int RNG_FLOOR_LSB = 0;
  localparam int RNG_CEIL_LSB = 4;
  // status fields
  localparam int STS1_LOCK = 0;
  localparam int STS1_PAR_FLAG = 1;
  localparam int STS1_LOCK_CHG = 4;
  localparam int STS2_CRC = 0;
  localparam int STS2_SEQ = 1;
  // dwell: 2.62 ms at 25 MHz reference clock
  localparam int DWELL_DEFAULT_US = 2620;
  localparam int REF_CLK_MHZ = 25;
  localparam int DWELL_DEFAULT_REF = DWELL_DEFAULT_US * REF_CLK_MHZ;
  // dwell length is DWELL_UNIT shifted by the 3-bit field
  localparam logic [19:0] DWELL_UNIT = 20'h01000;
  localparam logic [7:0] ACC_MAX = 8'hff;
  localparam logic [15:0] PAR_MAX = 16'hffff;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rxeq_req_type;

  typedef struct packed {
    logic clk_recovery;
    logic encoding;
    logic parity;
    logic crc;
    logic seq;
  } rxeq_err_type;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b01,
    ST_HOLD = 2'b10
  } rxeq_state_type;
endpackage

// ---- verif/rxeq_adapt_status_monitor.sv ----
`timescale 1ns/1ps
module rxeq_chk_monitor
  import rxeq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire rxeq_pkg::rxeq_req_type reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire rxeq_pkg::rxeq_err_type link_errors,
  input wire logic cdr_lock_pin,
  input wire logic reference_clock,
  input wire logic partner_compatible,
  input wire logic port_logic_reset,
  input wire logic [3:0] eq_gain_q,
  input wire logic parity_irq_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire rd_w = reg_req.rd;
  wire [7:0] ad_w = reg_req.addr;
  wire restart_w = reg_req.wr && ad_w == ADDR_EQ_CTL &&
    reg_req.wdata[CTL_RESTART] && !reg_req.wdata[CTL_FLOOR_EN];
  wire no_err_w = !link_errors.crc && !link_errors.seq;
  sequence sts2_pair_s;
    rd_w && ad_w == ADDR_STS_TWO && no_err_w ##1 no_err_w ##1
      rd_w && ad_w == ADDR_STS_TWO && no_err_w;
  endsequence
  sequence par_pair_s;
    rd_w && ad_w == ADDR_PAR_HI && !link_errors.parity ##1
      !link_errors.parity ##1
      rd_w && ad_w == ADDR_PAR_HI && !link_errors.parity;
  endsequence
  sequence quiet_unlock_s;
    $fell(cdr_lock_pin) ##0 (!cdr_lock_pin && !link_errors.parity) [*7];
  endsequence
  restart_min_a: assert property (
    restart_w |-> ##2 eq_gain_q == 4'h0)
    else $error("gain not at minimum after restart");
  result_read_a: assert property (
    rd_w && ad_w == ADDR_EQ_RES |=> reg_rdata_q[3:0] == $past(eq_gain_q))
    else $error("result register differs from gain");
  restart_clear_a: assert property (
    rd_w && ad_w == ADDR_EQ_CTL |=> !reg_rdata_q[CTL_RESTART])
    else $error("restart bit reads back set");
  sticky_clear_a: assert property (
    sts2_pair_s |=> reg_rdata_q[1:0] == 2'b00)
    else $error("fault flags survive a read");
  count_clear_a: assert property (
    par_pair_s |=> reg_rdata_q == 8'h00)
    else $error("parity count survives a read");
  irq_read_a: assert property (
    rd_w && ad_w == ADDR_PAR_HI && !link_errors.parity |=> !parity_irq_q)
    else $error("parity flag survives a read");
  irq_cause_a: assert property (
    $rose(parity_irq_q) |-> $past(link_errors.parity))
    else $error("parity interrupt without parity error");
  unlock_clear_a: assert property (
    quiet_unlock_s |=> !parity_irq_q)
    else $error("parity flag kept after lock loss");
  lock_live_a: assert property (
    $stable(cdr_lock_pin) [*6] ##0 rd_w && ad_w == ADDR_STS_ONE
      |=> reg_rdata_q[STS1_LOCK] == $past(cdr_lock_pin))
    else $error("lock status bit wrong");
endmodule
bind rxeq_adapt_status rxeq_chk_monitor chk_u (
  .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata_q(reg_rdata_q), .link_errors(link_errors),
  .cdr_lock_pin(cdr_lock_pin), .reference_clock(reference_clock),
  .partner_compatible(partner_compatible),
  .port_logic_reset(port_logic_reset), .eq_gain_q(eq_gain_q),
  .parity_irq_q(parity_irq_q)
);

// ---- verif/rxeq_ser_model.sv ----
`timescale 1ns/1ps
module rxeq_ser_model
  import rxeq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic lock_cmd,
  input wire rxeq_pkg::rxeq_err_type err_cmd,
  output logic cdr_lock_pin,
  output rxeq_pkg::rxeq_err_type link_errors,
  output logic partner_compatible
);
  logic [7:0] acq_q = 8'h00;
  initial cdr_lock_pin = 1'b0;
  initial link_errors = '0;
  assign partner_compatible = 1'b1;
  // lock takes a few cycles to acquire, but drops at once
  always @(posedge sys_clk) begin
    acq_q <= lock_cmd ? {acq_q[6:0], 1'b1} : 8'h00;
    cdr_lock_pin <= lock_cmd & acq_q[7];
    link_errors <= err_cmd;
  end
endmodule

// ---- verif/test_rxeq_adapt_status.sv ----
`timescale 1ns/1ps
module test_rxeq_adapt_status;
  import rxeq_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
  logic sys_clk = 1'b0, reset = 1'b1, reference_clock = 1'b0;
  logic port_logic_reset = 1'b0, lock_cmd = 1'b0;
  rxeq_req_type reg_req = '0;
  rxeq_err_type err_cmd = '0, link_errors;
  wire cdr_lock_pin, partner_compatible, parity_irq_q;
  wire [7:0] reg_rdata_q;
  wire [3:0] eq_gain_q;
  logic [7:0] rdat;
  int fail_count = 0, n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  always #20 reference_clock = ~reference_clock;
  rxeq_adapt_status dut_u (.sys_clk(sys_clk), .reset(reset),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .link_errors(link_errors), .cdr_lock_pin(cdr_lock_pin),
    .reference_clock(reference_clock),
    .partner_compatible(partner_compatible),
    .port_logic_reset(port_logic_reset), .eq_gain_q(eq_gain_q),
    .parity_irq_q(parity_irq_q));
  rxeq_ser_model ser_u (.sys_clk(sys_clk), .lock_cmd(lock_cmd),
    .err_cmd(err_cmd), .cdr_lock_pin(cdr_lock_pin),
    .link_errors(link_errors), .partner_compatible(partner_compatible));
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
    rdat = reg_rdata_q;
  endtask
  task automatic pulse(input rxeq_err_type e, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      err_cmd <= e;
      @(posedge sys_clk);
      err_cmd <= '0;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic t_reset_vals;
    logic [7:0] a[6] = '{ADDR_GEN_CFG, ADDR_ERR_SRC, ADDR_PAR_THR,
      ADDR_EQ_CTL, ADDR_EQ_RNG, 8'hff};
    logic [7:0] v[6] = '{RST_GEN_CFG, RST_ERR_SRC, RST_PAR_THR,
      RST_EQ_CTL, RST_EQ_RNG, 8'h00};
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, a[i], 8'h00);
      `CHK(rdat, v[i])
    end
  endtask
  task automatic t_sticky;
    pulse(5'b00011, 1);
    acc(1'b0, ADDR_STS_TWO, 8'h00);
    `CHK(rdat[1:0], 2'b11)
    acc(1'b0, ADDR_STS_TWO, 8'h00);
    `CHK(rdat[1:0], 2'b00)
  endtask
  task automatic t_parity;
    acc(1'b1, ADDR_PAR_THR, 8'h03);
    pulse(5'b00100, 2);
    idle(3);
    `CHK(parity_irq_q, 1'b0)
    pulse(5'b00100, 1);
    idle(3);
    `CHK(parity_irq_q, 1'b1)
    acc(1'b0, ADDR_PAR_HI, 8'h00);
    `CHK(parity_irq_q, 1'b0)
    `CHK(rdat, 8'h00)
    acc(1'b0, ADDR_PAR_LO, 8'h00);
    `CHK(rdat, 8'h03)
    // parity checking off: the count must not move
    acc(1'b1, ADDR_GEN_CFG, 8'h02);
    pulse(5'b00100, 2);
    acc(1'b0, ADDR_PAR_HI, 8'h00);
    acc(1'b0, ADDR_PAR_LO, 8'h00);
    `CHK(rdat, 8'h00)
    acc(1'b0, ADDR_PAR_HI, 8'h00);
    acc(1'b0, ADDR_PAR_HI, 8'h00);
    `CHK(rdat, 8'h00)
    acc(1'b1, ADDR_GEN_CFG, 8'h03);
  endtask
  task automatic t_search;
    int c;
    acc(1'b1, ADDR_EQ_RNG, 8'h65);
    acc(1'b1, ADDR_EQ_CTL, 8'h04);
    @(posedge sys_clk);
    port_logic_reset <= 1'b1;
    @(posedge sys_clk);
    port_logic_reset <= 1'b0;
    idle(3);
    `CHK(eq_gain_q, 4'h5)
    pulse(5'b10000, 3);
    c = 0;
    while (eq_gain_q === 4'h5 && c < 30000) begin
      @(negedge sys_clk);
      c++;
    end
    `CHK(eq_gain_q, 4'h6)
    `CHK(c > 20400 && c < 20560, 1'b1)
    c = 0;
    while (eq_gain_q === 4'h6 && c < 45000) begin
      @(negedge sys_clk);
      c++;
    end
    `CHK(eq_gain_q, 4'h5)
    `CHK(c > 40900 && c < 41020, 1'b1)
    acc(1'b1, ADDR_EQ_CTL, 8'h01);
    acc(1'b0, ADDR_EQ_RES, 8'h00);
    `CHK(rdat[3:0], 4'h0)
  endtask
  task automatic t_lock;
    @(posedge sys_clk);
    lock_cmd <= 1'b1;
    idle(30);
    acc(1'b0, ADDR_STS_ONE, 8'h00);
    `CHK(rdat[STS1_LOCK], 1'b1)
    `CHK(rdat[STS1_LOCK_CHG], 1'b1)
    acc(1'b0, ADDR_STS_ONE, 8'h00);
    `CHK(rdat[STS1_LOCK_CHG], 1'b0)
    acc(1'b1, ADDR_PAR_THR, 8'h01);
    pulse(5'b00100, 1);
    idle(3);
    `CHK(parity_irq_q, 1'b1)
    @(posedge sys_clk);
    lock_cmd <= 1'b0;
    idle(12);
    `CHK(parity_irq_q, 1'b0)
    acc(1'b0, ADDR_PAR_HI, 8'h00);
    acc(1'b0, ADDR_PAR_LO, 8'h00);
    `CHK(rdat, 8'h00)
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cut a hang short well after the two dwell waits
  initial begin
    #320000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_vals;
    t_sticky;
    t_parity;
    t_search;
    t_lock;
    give_verdict;
  end
endmodule
